// [core/cpb_pins.sv]
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cpb_regs.svh"
// Notes on behaviour
// RULE1 - Report port B bits 5-7 level and changes
// RULE2 - Output bits 0-1 follow control A, low
// RULE3 - Output bits 2-3 follow control B
// RULE4 - Initiator bit high for comms, low core
// RULE5 - Core bit: reservation on data, trace fetch
// RULE6 - Program trace strobe marks instruction fetches
// RULE7 - Transfer start marks bus and show cycles
// RULE8 - Burst bit thirty copies address when not bursting
// RULE9 - Burst pair copies address when not bursting
// RULE10 - Bursts advance burst address each beat, except from an asynchronous external master
// RULE11 - Internal card access: select equals size bit
// RULE12 - External card access: socket drives select
// RULE13 - One static function per shared pin
module cpb_pins (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [`CPB_AW-1:0]   reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [31:0]          reg_rdata,
    output logic                      irq,
    input  wire logic                 xfer_start,
    input  wire logic                 xfer_end,
    input  wire cpb_pkg::cpb_init_e   xfer_initiator,
    input  wire logic                 xfer_fetch,
    input  wire logic                 xfer_reserve,
    input  wire logic                 xfer_trace,
    input  wire logic                 xfer_burst,
    input  wire logic                 xfer_half_port,
    input  wire logic                 burst_beat,
    input  wire logic [2:0]           addr_28_30,
    input  wire logic                 fetch_active,
    input  wire logic                 internal_start,
    input  wire logic                 card_access,
    input  wire logic                 transfer_size_bit0,
    input  wire logic                 card_space_ext,
    input  wire logic [2:0]           card_input_port_b,
    output logic                      pin_b6_out,
    output logic                      pin_b6_oe,
    output logic                      pin_b7_out,
    output logic                      pin_b7_oe,
    output logic      [1:0]           card_output_port,
    output logic                      op2_sts_out,
    output logic                      op3_out,
    output logic      [1:0]           burst_addr_low_pair,
    output logic                      burst_addr_bit_thirty
);
    cpb_pkg::cpb_main_s s_r;
    cpb_pkg::cpb_main_s s_nxt;
    cpb_if              lnk ();

    logic                 wr_gca;
    logic                 wr_gcb;
    logic                 wr_clr;
    logic                 wr_en;
    logic                 wr_cfg;
    logic                 internal_nxt;
    logic [2:0]           clr_bits;
    cpb_pkg::cpb_p7_e     p7_sel;

    assign wr_gca = reg_write && reg_addr == `CPB_OFS_GCA;
    assign wr_gcb = reg_write && reg_addr == `CPB_OFS_GCB;
    assign wr_clr = reg_write && reg_addr == `CPB_OFS_CHG_CLR;
    assign wr_en  = reg_write && reg_addr == `CPB_OFS_CHG_EN;
    assign wr_cfg = reg_write && reg_addr == `CPB_OFS_PIN_CFG;
    assign clr_bits = wr_clr ? reg_wdata[`CPB_IPB_HI:`CPB_IPB_LO] : 3'h0;

    // Sense and burst helpers
    assign lnk.pin   = card_input_port_b;
    assign lnk.en    = {~^s_r.cfg[`CPB_CFG_P7_HI:`CPB_CFG_P7_LO],
                        !s_r.cfg[`CPB_CFG_P6], 1'b1}; // RULE13
    assign lnk.start = xfer_start;
    assign lnk.xend  = xfer_end;
    assign lnk.beat  = burst_beat;
    assign lnk.burst = xfer_burst;
    assign lnk.half  = xfer_half_port;
    assign lnk.init  = xfer_initiator;
    assign lnk.addr  = addr_28_30;

    cpb_sense u_sense (
        .clk   (clk),
        .reset (reset),
        .sns   (lnk.sense_mp)
    );

    cpb_burst u_burst (
        .clk   (clk),
        .reset (reset),
        .bst   (lnk.burst_mp)
    );

    always_comb begin
        s_nxt = s_r;
        internal_nxt = 1'b0;
        p7_sel = cpb_pkg::CPB_P7_INPUT;
        s_nxt.rdata = 32'h0;
        if (wr_gca) begin
            s_nxt.gca = reg_wdata[1:0];
        end
        if (wr_gcb) begin
            s_nxt.gcb = reg_wdata[1:0];
        end
        if (wr_en) begin
            s_nxt.chg_en = reg_wdata[`CPB_IPB_HI:`CPB_IPB_LO];
        end
        if (wr_cfg) begin
            s_nxt.cfg = reg_wdata[`CPB_CFG_W-1:0];
        end
        // Sticky change bits, a new change beats the clear
        s_nxt.chg = (s_r.chg & ~clr_bits) | lnk.chg; // RULE1
        if (reg_read) begin
            unique case (reg_addr)
                `CPB_OFS_GCA:       s_nxt.rdata = {30'h0, s_r.gca};
                `CPB_OFS_GCB:       s_nxt.rdata = {30'h0, s_r.gcb};
                `CPB_OFS_PIN_STATE: s_nxt.rdata = {24'h0, lnk.lvl, 5'h0};
                `CPB_OFS_PIN_CHG:   s_nxt.rdata = {24'h0, s_r.chg, 5'h0};
                `CPB_OFS_CHG_EN:    s_nxt.rdata = {24'h0, s_r.chg_en, 5'h0};
                `CPB_OFS_PIN_CFG:   s_nxt.rdata = {26'h0, s_r.cfg};
                default:            s_nxt.rdata = 32'h0;
            endcase
        end
        // Transaction context
        if (xfer_start) begin
            s_nxt.in_xfer = 1'b1;
            s_nxt.init = xfer_initiator;
            s_nxt.fetch = xfer_fetch;
            s_nxt.resv = xfer_reserve;
            s_nxt.trace = xfer_trace;
        end else if (xfer_end) begin
            s_nxt.in_xfer = 1'b0;
        end
        internal_nxt = s_nxt.init == cpb_pkg::CPB_INIT_CORE ||
                       s_nxt.init == cpb_pkg::CPB_INIT_COMMS;
        // Port B bit 6 as initiator type
        s_nxt.b6_out = s_nxt.init == cpb_pkg::CPB_INIT_COMMS; // RULE4
        s_nxt.b6_oe = s_nxt.cfg[`CPB_CFG_P6] && s_nxt.in_xfer &&
                      internal_nxt; // RULE13
        // Port B bit 7 as trace strobe or reservation bit
        p7_sel = cpb_pkg::cpb_p7_e'(s_nxt.cfg[`CPB_CFG_P7_HI:`CPB_CFG_P7_LO]);
        unique case (p7_sel)
            cpb_pkg::CPB_P7_TRACE: begin
                s_nxt.b7_out = fetch_active; // RULE6
                s_nxt.b7_oe = 1'b1;
            end
            cpb_pkg::CPB_P7_RESERVE: begin
                s_nxt.b7_out = s_nxt.fetch ? s_nxt.trace : s_nxt.resv; // RULE5
                s_nxt.b7_oe = s_nxt.in_xfer &&
                              s_nxt.init == cpb_pkg::CPB_INIT_CORE;
            end
            default: begin
                s_nxt.b7_out = 1'b0;
                s_nxt.b7_oe = 1'b0;
            end
        endcase
        // Transfer start strobe
        s_nxt.sts = xfer_start ||
                    (internal_start && s_nxt.cfg[`CPB_CFG_SHOW]); // RULE7
        s_nxt.op[1:0] = s_nxt.gca; // RULE2
        s_nxt.op[3:2] = s_nxt.gcb; // RULE3
        // Card space select
        if (card_access && internal_nxt) begin
            s_nxt.reg_out = transfer_size_bit0; // RULE11
        end else if (card_access) begin
            s_nxt.reg_out = card_space_ext; // RULE12
        end else begin
            s_nxt.reg_out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.gca <= `CPB_RST_GC;
            s_r.gcb <= `CPB_RST_GC;
            s_r.cfg <= `CPB_RST_CFG;
            s_r.chg_en <= `CPB_RST_EN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign irq = |(s_r.chg & s_r.chg_en);
    assign pin_b6_out = s_r.b6_out;
    assign pin_b6_oe = s_r.b6_oe;
    assign pin_b7_out = s_r.b7_out;
    assign pin_b7_oe = s_r.b7_oe;
    assign card_output_port = s_r.op[1:0];
    assign op2_sts_out = s_r.cfg[`CPB_CFG_STS] ? s_r.sts : s_r.op[2];
    assign op3_out = s_r.op[3];
    assign burst_addr_low_pair = lnk.baddr[2:1];
    assign burst_addr_bit_thirty = s_r.cfg[`CPB_CFG_REG] ? s_r.reg_out :
                                   lnk.baddr[0]; // RULE13

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_change_sets;
        (|lnk.chg) |=> ((s_r.chg & $past(lnk.chg)) == $past(lnk.chg));
    endproperty
    a_change_sets: assert property (p_change_sets) // RULE1
        else $error("pin change not held in change register");

    property p_chg_clear;
        wr_clr && !(|lnk.chg) |=> (s_r.chg & $past(clr_bits)) == 3'h0;
    endproperty
    a_chg_clear: assert property (p_chg_clear) // RULE1
        else $error("change bit not cleared by clear write");

    property p_op_a;
        wr_gca |=> card_output_port == $past(reg_wdata[1:0]) ##1
                   ($past(wr_gca) ||
                    card_output_port == $past(reg_wdata[1:0], 2));
    endproperty
    a_op_a: assert property (p_op_a) // RULE2
        else $error("output bits 0-1 do not follow control A");

    property p_op_b;
        wr_gcb |=> op3_out == $past(reg_wdata[1]);
    endproperty
    a_op_b: assert property (p_op_b) // RULE3
        else $error("output bit 3 does not follow control B");

    property p_init_type;
        xfer_start && !reg_write && s_r.cfg[`CPB_CFG_P6] &&
            xfer_initiator != cpb_pkg::CPB_INIT_EXT_ASYNC &&
            xfer_initiator != cpb_pkg::CPB_INIT_EXT_SYNC
            |=> pin_b6_oe &&
                pin_b6_out == ($past(xfer_initiator) ==
                               cpb_pkg::CPB_INIT_COMMS);
    endproperty
    a_init_type: assert property (p_init_type) // RULE4
        else $error("initiator type bit wrong after start");

    property p_resv;
        xfer_start && !reg_write && !xfer_fetch &&
            xfer_initiator == cpb_pkg::CPB_INIT_CORE &&
            s_r.cfg[`CPB_CFG_P7_HI:`CPB_CFG_P7_LO] == 2'h2
            |=> pin_b7_oe && pin_b7_out == $past(xfer_reserve);
    endproperty
    a_resv: assert property (p_resv) // RULE5
        else $error("reservation bit not driven on data transfer");

    property p_trace;
        fetch_active && !reg_write &&
            s_r.cfg[`CPB_CFG_P7_HI:`CPB_CFG_P7_LO] == 2'h1
            |=> pin_b7_oe && pin_b7_out;
    endproperty
    a_trace: assert property (p_trace) // RULE6
        else $error("program trace not asserted on fetch");

    property p_sts;
        (xfer_start || (internal_start && s_r.cfg[`CPB_CFG_SHOW])) &&
            s_r.cfg[`CPB_CFG_STS] && !reg_write |=> op2_sts_out;
    endproperty
    a_sts: assert property (p_sts) // RULE7
        else $error("transfer start strobe missing");

    property p_reg_ext;
        card_access && !xfer_start && !reg_write && s_r.cfg[`CPB_CFG_REG] &&
            (s_r.init == cpb_pkg::CPB_INIT_EXT_ASYNC ||
             s_r.init == cpb_pkg::CPB_INIT_EXT_SYNC)
            |=> burst_addr_bit_thirty == $past(card_space_ext);
    endproperty
    a_reg_ext: assert property (p_reg_ext) // RULE12
        else $error("card space select not from socket interface");

    property p_reg_int;
        card_access && !xfer_start && !reg_write && s_r.cfg[`CPB_CFG_REG] &&
            (s_r.init == cpb_pkg::CPB_INIT_CORE ||
             s_r.init == cpb_pkg::CPB_INIT_COMMS)
            |=> burst_addr_bit_thirty == $past(transfer_size_bit0);
    endproperty
    a_reg_int: assert property (p_reg_int) // RULE11
        else $error("card space select differs from size bit");

    property p_excl;
        !$past(reg_write) && pin_b7_oe |-> !lnk.en[2] && !lnk.chg[2];
    endproperty
    a_excl: assert property (p_excl) // RULE13
        else $error("driven pin is also sampled");

    c_irq:       cover property (irq ##1 wr_clr ##1 !irq);
    c_show:      cover property (internal_start && s_r.cfg[`CPB_CFG_SHOW]);
    c_card_ext:  cover property (card_access && s_r.cfg[`CPB_CFG_REG]);
endmodule : cpb_pins
`default_nettype wire

// [core/cpb_regs.svh]
`ifndef CPB_REGS_SVH
`define CPB_REGS_SVH

// Register offsets, byte addresses
`define CPB_AW            8
`define CPB_OFS_GCA       8'h00
`define CPB_OFS_GCB       8'h04
`define CPB_OFS_PIN_STATE 8'h08
`define CPB_OFS_PIN_CHG   8'h0C
`define CPB_OFS_CHG_CLR   8'h10
`define CPB_OFS_CHG_EN    8'h14
`define CPB_OFS_PIN_CFG   8'h18

// Pin configuration fields
`define CPB_CFG_W         6
`define CPB_CFG_P6        0
`define CPB_CFG_P7_LO     1
`define CPB_CFG_P7_HI     2
`define CPB_CFG_STS       3
`define CPB_CFG_REG       4
`define CPB_CFG_SHOW      5

// Port B sense bits 5 to 7 in state, change, clear and enable
`define CPB_IPB_LO        5
`define CPB_IPB_HI        7

// Reset values
`define CPB_RST_GC        2'h0
`define CPB_RST_CFG       6'h00
`define CPB_RST_EN        3'h0

// Burst address steps per beat
`define CPB_STEP_HALF     3'h1
`define CPB_STEP_WORD     3'h2

`endif

// [core/cpb_pkg.sv]
`include "cpb_regs.svh"
package cpb_pkg;

    typedef enum logic [1:0] {
        CPB_INIT_CORE      = 2'b00,
        CPB_INIT_COMMS     = 2'b01,
        CPB_INIT_EXT_ASYNC = 2'b10,
        CPB_INIT_EXT_SYNC  = 2'b11
    } cpb_init_e;

    typedef enum logic [1:0] {
        CPB_P7_INPUT   = 2'b00,
        CPB_P7_TRACE   = 2'b01,
        CPB_P7_RESERVE = 2'b10
    } cpb_p7_e;

    typedef enum logic {
        CPB_BST_IDLE = 1'b0,
        CPB_BST_RUN  = 1'b1
    } cpb_bst_e;

    typedef struct packed {
        logic [1:0]            gca;
        logic [1:0]            gcb;
        logic [`CPB_CFG_W-1:0] cfg;
        logic [2:0]            chg_en;
        logic [2:0]            chg;
        logic [31:0]           rdata;
        logic                  in_xfer;
        cpb_init_e             init;
        logic                  fetch;
        logic                  resv;
        logic                  trace;
        logic                  b6_out;
        logic                  b6_oe;
        logic                  b7_out;
        logic                  b7_oe;
        logic                  sts;
        logic [3:0]            op;
        logic                  reg_out;
    } cpb_main_s;

    typedef struct packed {
        cpb_bst_e   st;
        logic [2:0] baddr;
        logic [2:0] step;
    } cpb_burst_s;

    typedef struct packed {
        logic [2:0] lvl;
        logic [2:0] chg;
    } cpb_sense_s;

endpackage : cpb_pkg

// [core/cpb_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cpb_if;
    logic               start;
    logic               xend;
    logic               beat;
    logic               burst;
    logic               half;
    cpb_pkg::cpb_init_e init;
    logic [2:0]         addr;
    logic [2:0]         baddr;
    logic [2:0]         pin;
    logic [2:0]         en;
    logic [2:0]         lvl;
    logic [2:0]         chg;

    modport burst_mp  (input start, xend, beat, burst, half, init, addr,
                       output baddr);
    modport burst_ctl (output start, xend, beat, burst, half, init, addr,
                       input baddr);
    modport sense_mp  (input pin, en, output lvl, chg);
    modport sense_ctl (output pin, en, input lvl, chg);
endinterface : cpb_if
`default_nettype wire

// [core/cpb_sense.sv]
`timescale 1ns/1ps
`default_nettype none
module cpb_sense (
    input  wire logic clk,
    input  wire logic reset,
    cpb_if.sense_mp   sns
);
    cpb_pkg::cpb_sense_s s_r;
    cpb_pkg::cpb_sense_s s_nxt;

    // Level and change, gated bits are not sampled
    always_comb begin
        s_nxt = s_r;
        s_nxt.lvl = sns.pin & sns.en; // RULE13
        s_nxt.chg = (s_nxt.lvl ^ s_r.lvl) & sns.en; // RULE1
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sns.lvl = s_r.lvl;
    assign sns.chg = s_r.chg;
endmodule : cpb_sense
`default_nettype wire

// [core/cpb_burst.sv]
`timescale 1ns/1ps
`default_nettype none
module cpb_burst (
    input  wire logic clk,
    input  wire logic reset,
    cpb_if.burst_mp   bst
);
    cpb_pkg::cpb_burst_s s_r;
    cpb_pkg::cpb_burst_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            cpb_pkg::CPB_BST_IDLE: begin
                s_nxt.baddr = bst.addr; // RULE8
                if (bst.start && bst.burst &&
                    bst.init != cpb_pkg::CPB_INIT_EXT_ASYNC) begin
                    s_nxt.st = cpb_pkg::CPB_BST_RUN;
                    s_nxt.step = bst.half ? `CPB_STEP_HALF : `CPB_STEP_WORD;
                end
            end
            cpb_pkg::CPB_BST_RUN: begin
                if (bst.start || bst.xend) begin
                    s_nxt.st = cpb_pkg::CPB_BST_IDLE;
                    s_nxt.baddr = bst.addr; // RULE9
                end else if (bst.beat) begin
                    s_nxt.baddr = 3'(s_r.baddr + s_r.step); // RULE10
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bst.baddr = s_r.baddr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_copy_thirty;
        s_r.st == cpb_pkg::CPB_BST_IDLE |=> bst.baddr[0] == $past(bst.addr[0]);
    endproperty
    a_copy_thirty: assert property (p_copy_thirty) // RULE8
        else $error("burst bit thirty does not copy address");

    property p_copy_pair;
        s_r.st == cpb_pkg::CPB_BST_IDLE
            |=> bst.baddr[2:1] == $past(bst.addr[2:1]);
    endproperty
    a_copy_pair: assert property (p_copy_pair) // RULE9
        else $error("burst pair does not copy address");

    property p_advance;
        s_r.st == cpb_pkg::CPB_BST_RUN && bst.beat && !bst.start && !bst.xend
            |=> bst.baddr == 3'($past(s_r.baddr) + $past(s_r.step));
    endproperty
    a_advance: assert property (p_advance) // RULE10
        else $error("burst address did not advance on beat");

    property p_async_no_run;
        bst.start && bst.init == cpb_pkg::CPB_INIT_EXT_ASYNC
            |=> s_r.st == cpb_pkg::CPB_BST_IDLE;
    endproperty
    a_async_no_run: assert property (p_async_no_run) // RULE10
        else $error("asynchronous master entered burst advance");

    c_burst_beats: cover property (
        s_r.st == cpb_pkg::CPB_BST_RUN && bst.beat ##1 bst.beat);
endmodule : cpb_burst
`default_nettype wire

// [test/cpb_socket_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpb_socket_model (
    input  wire logic       pin_b6_out,
    input  wire logic       pin_b6_oe,
    input  wire logic       pin_b7_out,
    input  wire logic       pin_b7_oe,
    input  wire logic [2:0] sock_lvl,
    output logic      [2:0] card_input_port_b
);
    // Socket always drives its sense lines; a driving device owns the wire
    assign card_input_port_b[0] = sock_lvl[0];
    assign card_input_port_b[1] = pin_b6_oe ? pin_b6_out : sock_lvl[1];
    assign card_input_port_b[2] = pin_b7_oe ? pin_b7_out : sock_lvl[2];
endmodule : cpb_socket_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic               clk, reset, reg_write, reg_read, irq;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata, reg_rdata;
    logic               xfer_start, xfer_end, xfer_fetch, xfer_reserve;
    logic               xfer_trace, xfer_burst, xfer_half_port, burst_beat;
    cpb_pkg::cpb_init_e xfer_initiator;
    logic [2:0]         addr_28_30, card_input_port_b, sock_lvl;
    logic               fetch_active, internal_start, card_access;
    logic               transfer_size_bit0, card_space_ext;
    logic               pin_b6_out, pin_b6_oe, pin_b7_out, pin_b7_oe;
    logic [1:0]         card_output_port, burst_addr_low_pair;
    logic               op2_sts_out, op3_out, burst_addr_bit_thirty;
    int                 err_count, samples_checked;
    int                 m_gca, m_gcb, p, q, e;
    logic [31:0]        d;

    cpb_pins cpb_pins_inst (.clk, .reset, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .irq, .xfer_start, .xfer_end, .xfer_initiator,
        .xfer_fetch, .xfer_reserve, .xfer_trace, .xfer_burst, .xfer_half_port,
        .burst_beat, .addr_28_30, .fetch_active, .internal_start,
        .card_access, .transfer_size_bit0, .card_space_ext,
        .card_input_port_b, .pin_b6_out, .pin_b6_oe, .pin_b7_out, .pin_b7_oe,
        .card_output_port, .op2_sts_out, .op3_out, .burst_addr_low_pair,
        .burst_addr_bit_thirty);
    cpb_socket_model cpb_socket_model_inst (.pin_b6_out, .pin_b6_oe,
        .pin_b7_out, .pin_b7_oe, .sock_lvl, .card_input_port_b);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tk;
        @(posedge clk);
    endtask : tk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        tk;
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        tk;
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        tk;
        reg_addr <= a;
        reg_read <= 1'b1;
        tk;
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic start(input int i, input logic bu, input logic hp);
        tk;
        xfer_start     <= 1'b1;
        xfer_initiator <= cpb_pkg::cpb_init_e'(i);
        xfer_burst     <= bu;
        xfer_half_port <= hp;
        tk;
        xfer_start     <= 1'b0;
    endtask : start

    task automatic finish_xfer;
        tk;
        xfer_end <= 1'b1;
        tk;
        xfer_end <= 1'b0;
        #1;
    endtask : finish_xfer

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test;
    end

    initial begin
        int f, t, r, a, x, st, ini;
        {reg_write, reg_read, xfer_start, xfer_end, xfer_fetch} = '0;
        {xfer_reserve, xfer_trace, xfer_burst, xfer_half_port} = '0;
        {burst_beat, fetch_active, internal_start, card_access} = '0;
        {transfer_size_bit0, card_space_ext, reg_addr, reg_wdata} = '0;
        xfer_initiator = cpb_pkg::CPB_INIT_CORE;
        addr_28_30 = 3'h0;
        sock_lvl = 3'h0;
        err_count = 0;
        samples_checked = 0;
        reset = 1'b1;
        void'($urandom(11));
        repeat (4) tk;
        reset <= 1'b0;
        tk;
        #1;
        chk({card_output_port, op3_out, irq}, 0);
        // Control registers to output port bits
        m_gca = $urandom % 4;
        m_gcb = $urandom % 4;
        wr(8'h00, m_gca);
        wr(8'h04, m_gcb);
        tk;
        #1;
        chk(card_output_port, m_gca);
        chk({op3_out, op2_sts_out}, m_gcb);
        rd(8'h00, d);
        chk(d, m_gca);
        rd(8'h1C, d);
        chk(d, 0);
        $display("test control done");
        // Pin sense, change flags and interrupt
        p = ($urandom % 8) | 1;
        q = $urandom % 8;
        e = ($urandom % 7) + 1;
        tk;
        sock_lvl <= p[2:0];
        repeat (3) tk;
        rd(8'h08, d);
        chk(d, 32'(p << 5));
        rd(8'h0C, d);
        chk(d, 32'(p << 5));
        wr(8'h14, 32'(e << 5));
        tk;
        #1;
        chk(irq, (p & e) != 0);
        wr(8'h10, 32'hE0);
        tk;
        #1;
        chk(irq, 0);
        tk;
        sock_lvl <= q[2:0];
        repeat (3) tk;
        rd(8'h0C, d);
        chk(d, 32'((p ^ q) << 5));
        wr(8'h10, 32'hE0);
        wr(8'h14, 32'h0);
        $display("test sense done");
        // Address type pins and transfer start
        wr(8'h18, 32'h0D);
        for (int i = 0; i < 4; i++) begin
            f = $urandom % 2;
            t = $urandom % 2;
            r = $urandom % 2;
            tk;
            xfer_fetch   <= f[0];
            xfer_trace   <= t[0];
            xfer_reserve <= r[0];
            start(i, 1'b0, 1'b0);
            #1;
            chk(pin_b6_oe, i < 2);
            if (i < 2) chk(pin_b6_out, i == 1);
            chk(pin_b7_oe, i == 0);
            if (i == 0) chk(pin_b7_out, f ? t : r);
            chk(op2_sts_out, 1);
            tk;
            #1;
            chk(op2_sts_out, 0);
            finish_xfer;
            chk({pin_b6_oe, pin_b7_oe}, 0);
        end
        $display("test address type done");
        // Trace strobe and show cycles
        wr(8'h18, 32'h02);
        for (int v = 1; v >= 0; v--) begin
            tk;
            fetch_active <= v[0];
            repeat (2) tk;
            #1;
            chk({pin_b7_oe, pin_b7_out}, {1'b1, v[0]});
        end
        wr(8'h18, 32'h06);
        rd(8'h08, d);
        chk(pin_b7_oe, 0);
        chk(d, 32'(q << 5));
        wr(8'h18, 32'h28);
        tk;
        internal_start <= 1'b1;
        tk;
        internal_start <= 1'b0;
        #1;
        chk(op2_sts_out, 1);
        tk;
        #1;
        chk(op2_sts_out, 0);
        $display("test trace done");
        // Burst address copy and advance
        wr(8'h18, 32'h00);
        for (int k = 0; k < 6; k++) begin
            a = $urandom % 8;
            ini = (k < 2) ? 0 : ((k < 4) ? 3 : 2);
            st = (k % 2) ? 1 : 2;
            tk;
            addr_28_30 <= a[2:0];
            repeat (2) tk;
            #1;
            chk({burst_addr_low_pair, burst_addr_bit_thirty}, a);
            start(ini, 1'b1, k[0]);
            addr_28_30 <= ~a[2:0];
            #1;
            chk({burst_addr_low_pair, burst_addr_bit_thirty}, a);
            for (int n = 1; n < 3; n++) begin
                tk;
                burst_beat <= 1'b1;
                tk;
                burst_beat <= 1'b0;
                #1;
                x = (ini == 2) ? (~a & 7) : ((a + n * st) & 7);
                chk({burst_addr_low_pair, burst_addr_bit_thirty}, x);
            end
            finish_xfer;
        end
        $display("test burst done");
        // Card space select
        wr(8'h18, 32'h10);
        for (int i = 0; i < 4; i++) begin
            f = $urandom % 2;
            t = $urandom % 2;
            tk;
            card_access        <= 1'b1;
            transfer_size_bit0 <= f[0];
            card_space_ext     <= t[0];
            start(i, 1'b0, 1'b0);
            tk;
            #1;
            chk(burst_addr_bit_thirty, (i < 2) ? f : t);
            tk;
            card_access <= 1'b0;
            finish_xfer;
        end
        $display("test card select done");
        tk;
        reset <= 1'b1;
        repeat (2) tk;
        reset <= 1'b0;
        tk;
        #1;
        chk({card_output_port, op3_out, op2_sts_out, irq}, 0);
        $display("test reset done");
        stop_test;
    end
endmodule : testbench
`default_nettype wire
